// ---- design/pcp_paired_channel_pwm.sv ----
// Overview of operation
// - Master runs as repeating interval timer, paired slave in one-count mode.
// - Period equals master data value plus one count clocks.
// - Duty equals slave data over master data plus one, in percent.
// - Count clock from unit prescaler plus per-channel clock and source selects.
// - Writing 1 to a start bit, or upper-half start, begins counting.
// - Writing 1 to a stop bit, or upper-half stop, halts counting.
// - Mode bit 0 selects whether a start also raises the master interrupt.
// - Master interrupt fires whenever its down-counter reaches zero.
// - Each master interrupt reloads slave counter from its data register.
// - Slave interrupt fires when its down-counter reaches zero.
// - Count registers are read-only; data registers read and write.
// - Only channels 0 and 2 are masters; channel 2 serves only slave 3.
// - Software picks the starting pin level and port or PWM use per pin.
// - Enable status shows each running counter plus upper halves of 1 and 3.
// - In split mode upper-half start bits start only the upper 8-bit timer.
// - In split mode upper-half stop bits stop only the upper 8-bit timer.
// - Master select on channel 2 and split select on 1 and 3 set linking.
// - Split select exists only on channels 1 and 3.
`timescale 1ns/1ps
`default_nettype none

module pcp_paired_channel_pwm (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] event_in,
  output logic [3:0] timer_out,
  output logic [3:0] chan_irq,
  output logic [1:0] upper_irq
);

  function automatic logic tick_of(input logic [15:0] cnt, input logic [3:0] sel);
    logic [15:0] mask;
    mask = (16'h0001 << sel) - 16'h0001;
    return (cnt & mask) == mask;
  endfunction

  // Group master feeding a slave
  function automatic int master_of(input int n, input logic ch2_master);
    return (n == 3 && ch2_master) ? 2 : 0;
  endfunction

  function automatic logic is_chan_reg(input logic [7:0] addr, input logic [7:0] base);
    return addr[7:4] == base[7:4] && addr[1:0] == 2'b00;
  endfunction

  logic [3:0] ev_sync1;
  logic [3:0] ev_sync2;
  logic [3:0] ev_prev;
  logic [3:0] ev_rise;
  logic [15:0] pre_cnt;
  logic [7:0] prescaler;
  logic [11:0] outctl;
  pcp_pkg::pcp_mode_t mode [4];
  logic [15:0] data [4];
  logic [15:0] count [4];
  logic [15:0] next_count [4];
  logic [3:0] running;
  logic [3:0] upper_run;
  logic [3:0] active;
  logic [3:0] out_state;
  logic ck0_tick;
  logic ck1_tick;
  logic [3:0] tick;
  logic [3:0] split;
  logic [3:0] interval;
  logic [3:0] zero_lo;
  logic [3:0] zero_hi;
  logic [3:0] last_lo;
  logic [3:0] start_w;
  logic [3:0] stop_w;
  logic [3:0] upper_start_w;
  logic [3:0] upper_stop_w;
  logic [3:0] fire;
  logic [3:0] fire_hi;
  logic [3:0] trig;
  logic [3:0] end_one;
  logic [3:0] load_lo;
  logic [3:0] dec_lo;
  logic [3:0] load_hi;
  logic [3:0] dec_hi;
  logic wr;
  logic [31:0] rd_val;
  logic rd_bad;
  logic ch2_master;

  assign wr = psel & penable & pwrite & pready;
  assign ch2_master = mode[2].role_select;
  assign ev_rise = ev_sync2 & ~ev_prev;
  assign ck0_tick = tick_of(pre_cnt, prescaler[pcp_pkg::PRE_CK0_LSB +: 4]);
  assign ck1_tick = tick_of(pre_cnt, prescaler[pcp_pkg::PRE_CK1_LSB +: 4]);

  // Event inputs cross into clk
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ev_sync1 <= 4'h0;
      ev_sync2 <= 4'h0;
      ev_prev <= 4'h0;
    end
    else
    begin
      ev_sync1 <= event_in;
      ev_sync2 <= ev_sync1;
      ev_prev <= ev_sync2;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pre_cnt <= 16'h0000;
    end
    else
    begin
      pre_cnt <= pre_cnt + 16'h0001;
    end
  end

  // Per-channel decode of triggers and events
  always_comb
  begin
    for (int n = 0; n < 4; n++)
    begin
      tick[n] = mode[n].count_source_select ? ev_rise[n] :
        (mode[n].clock_select == pcp_pkg::CKS_CK1 ? ck1_tick : ck0_tick);
      split[n] = (n == 1 || n == 3) && mode[n].role_select;
      interval[n] = mode[n].op_mode != pcp_pkg::PCP_OP_ONE_COUNT;
      zero_lo[n] = split[n] ? (count[n][7:0] == 8'h00) : (count[n] == 16'h0000);
      zero_hi[n] = count[n][15:8] == 8'h00;
      last_lo[n] = split[n] ? (count[n][7:0] == 8'h01) : (count[n] == 16'h0001);
      start_w[n] = wr && paddr == pcp_pkg::OFS_START && pwdata[n];
      stop_w[n] = wr && paddr == pcp_pkg::OFS_STOP && pwdata[n];
      upper_start_w[n] = 1'b0;
      upper_stop_w[n] = 1'b0;
    end
    upper_start_w[1] = split[1] && wr && paddr == pcp_pkg::OFS_START && pwdata[pcp_pkg::UPPER_CH1_BIT];
    upper_start_w[3] = split[3] && wr && paddr == pcp_pkg::OFS_START && pwdata[pcp_pkg::UPPER_CH3_BIT];
    upper_stop_w[1] = wr && paddr == pcp_pkg::OFS_STOP && pwdata[pcp_pkg::UPPER_CH1_BIT];
    upper_stop_w[3] = wr && paddr == pcp_pkg::OFS_STOP && pwdata[pcp_pkg::UPPER_CH3_BIT];
    for (int n = 0; n < 4; n++)
    begin
      // One-count ends on the tick that brings the counter to zero
      end_one[n] = running[n] && active[n] && tick[n] && (zero_lo[n] || last_lo[n]);
      // Interval: fire on start if selected, then at each zero
      fire[n] = interval[n] ? (start_w[n] && mode[n].start_irq_select) ||
        (running[n] && tick[n] && zero_lo[n]) : end_one[n];
      fire_hi[n] = upper_run[n] && tick[n] && zero_hi[n];
    end
    for (int n = 0; n < 4; n++)
    begin
      // Slaves only: channel 0 always master, channel 2 when selected
      trig[n] = !(n == 0 || (n == 2 && ch2_master) || interval[n]) &&
        running[n] && !start_w[n] && fire[master_of(n, ch2_master)];
      load_lo[n] = (start_w[n] && interval[n]) || trig[n] || (interval[n] && running[n] && tick[n] && zero_lo[n]);
      dec_lo[n] = running[n] && tick[n] && !zero_lo[n] && (interval[n] || active[n]) && !trig[n] && !start_w[n];
      load_hi[n] = upper_start_w[n] || fire_hi[n];
      dec_hi[n] = upper_run[n] && tick[n] && !zero_hi[n] && !upper_start_w[n];
    end
  end

  always_comb
  begin
    for (int n = 0; n < 4; n++)
    begin
      next_count[n] = count[n];
      if (load_lo[n])
        next_count[n] = split[n] ? {count[n][15:8], data[n][7:0]} : data[n];
      else if (dec_lo[n])
        next_count[n] = split[n] ? {count[n][15:8], count[n][7:0] - 8'h01} : count[n] - 16'h0001;
      if (split[n] && load_hi[n])
        next_count[n][15:8] = data[n][15:8];
      else if (split[n] && dec_hi[n])
        next_count[n][15:8] = count[n][15:8] - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int n = 0; n < 4; n++)
        count[n] <= pcp_pkg::RST_COUNT;
    end
    else
    begin
      for (int n = 0; n < 4; n++)
        count[n] <= next_count[n];
    end
  end

  // Run flags and one-count activity
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      running <= 4'h0;
      upper_run <= 4'h0;
      active <= 4'h0;
    end
    else
    begin
      for (int n = 0; n < 4; n++)
      begin
        if (stop_w[n])
        begin
          running[n] <= 1'b0;
          active[n] <= 1'b0;
        end
        else if (start_w[n])
        begin
          running[n] <= 1'b1;
          active[n] <= 1'b0;
        end
        else if (trig[n])
          active[n] <= 1'b1;
        else if (end_one[n])
          active[n] <= 1'b0;
        if (upper_stop_w[n] || !split[n])
          upper_run[n] <= 1'b0;
        else if (upper_start_w[n])
          upper_run[n] <= 1'b1;
      end
    end
  end

  // Pin level: start level, then pulse edges
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_state <= 4'h0;
      timer_out <= 4'h0;
    end
    else
    begin
      for (int n = 0; n < 4; n++)
      begin
        if (start_w[n])
          out_state[n] <= outctl[pcp_pkg::OUT_INIT_LSB + n];
        else if (trig[n])
          out_state[n] <= 1'b1;
        else if (end_one[n])
          out_state[n] <= 1'b0;
        else if (interval[n] && fire[n])
          out_state[n] <= ~out_state[n];
        timer_out[n] <= outctl[pcp_pkg::OUT_EN_LSB + n] ? out_state[n] : outctl[pcp_pkg::OUT_PORT_LSB + n];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      chan_irq <= 4'h0;
      upper_irq <= 2'b00;
    end
    else
    begin
      chan_irq <= fire;
      upper_irq <= {fire_hi[3], fire_hi[1]};
    end
  end

  // Software-written configuration
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prescaler <= pcp_pkg::RST_PRESCALER;
      outctl <= pcp_pkg::RST_OUTCTL;
      for (int n = 0; n < 4; n++)
      begin
        mode[n] <= pcp_pkg::pcp_mode_t'(pcp_pkg::RST_MODE);
        data[n] <= pcp_pkg::RST_DATA;
      end
    end
    else if (wr)
    begin
      if (paddr == pcp_pkg::OFS_PRESCALER)
        prescaler <= pwdata[7:0];
      else if (paddr == pcp_pkg::OFS_OUTCTL)
        outctl <= pwdata[11:0];
      else if (is_chan_reg(paddr, pcp_pkg::OFS_MODE))
      begin
        // Role bit only on channels 1, 2 and 3
        if (paddr[3:2] == 2'd0)
          mode[0] <= pcp_pkg::pcp_mode_t'(pwdata[15:0] & pcp_pkg::MODE_WMASK_PLAIN);
        else
          mode[paddr[3:2]] <= pcp_pkg::pcp_mode_t'(pwdata[15:0] & pcp_pkg::MODE_WMASK_ROLE);
      end
      else if (is_chan_reg(paddr, pcp_pkg::OFS_DATA))
        data[paddr[3:2]] <= pwdata[15:0];
    end
  end

  // Read decode
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_bad = 1'b0;
    if (paddr == pcp_pkg::OFS_PRESCALER)
      rd_val[7:0] = prescaler;
    else if (paddr == pcp_pkg::OFS_START || paddr == pcp_pkg::OFS_STOP)
      rd_val = 32'h0000_0000;
    else if (paddr == pcp_pkg::OFS_ENABLE)
    begin
      rd_val[3:0] = running;
      rd_val[pcp_pkg::UPPER_CH1_BIT] = upper_run[1];
      rd_val[pcp_pkg::UPPER_CH3_BIT] = upper_run[3];
    end
    else if (paddr == pcp_pkg::OFS_OUTCTL)
      rd_val[11:0] = outctl;
    else if (is_chan_reg(paddr, pcp_pkg::OFS_MODE))
      rd_val[15:0] = mode[paddr[3:2]];
    else if (is_chan_reg(paddr, pcp_pkg::OFS_DATA))
      rd_val[15:0] = data[paddr[3:2]];
    else if (is_chan_reg(paddr, pcp_pkg::OFS_COUNT))
      rd_val[15:0] = count[paddr[3:2]];
    else
      rd_bad = 1'b1;
  end

  // APB slave: answer in the first access cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      if (!pwrite)
        prdata <= rd_val;
      pready <= 1'b1;
      pslverr <= rd_bad;
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ---- include/pcp_pkg.sv ----
package pcp_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_PRESCALER = 8'h00;
  localparam logic [7:0] OFS_START = 8'h04;
  localparam logic [7:0] OFS_STOP = 8'h08;
  localparam logic [7:0] OFS_ENABLE = 8'h0C;
  localparam logic [7:0] OFS_OUTCTL = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h20;
  localparam logic [7:0] OFS_DATA = 8'h30;
  localparam logic [7:0] OFS_COUNT = 8'h40;

  // Field positions
  localparam int PRE_CK0_LSB = 0;
  localparam int PRE_CK1_LSB = 4;
  localparam int UPPER_CH1_BIT = 9;
  localparam int UPPER_CH3_BIT = 11;
  localparam int OUT_EN_LSB = 0;
  localparam int OUT_INIT_LSB = 4;
  localparam int OUT_PORT_LSB = 8;

  // Reset values
  localparam logic [7:0] RST_PRESCALER = 8'h00;
  localparam logic [11:0] RST_OUTCTL = 12'h000;
  localparam logic [15:0] RST_MODE = 16'h0000;
  localparam logic [15:0] RST_DATA = 16'hFFFF;
  localparam logic [15:0] RST_COUNT = 16'hFFFF;

  // Writable bits of each channel mode register
  localparam logic [15:0] MODE_WMASK_PLAIN = 16'hD00F;
  localparam logic [15:0] MODE_WMASK_ROLE = 16'hD80F;

  // Clock select codes
  localparam logic [1:0] CKS_CK0 = 2'b00;
  localparam logic [1:0] CKS_CK1 = 2'b01;

  typedef enum logic [2:0] {
    PCP_OP_INTERVAL = 3'b000,
    PCP_OP_ONE_COUNT = 3'b100
  } pcp_op_t;

  typedef struct packed {
    logic [1:0] clock_select;
    logic rsvd13;
    logic count_source_select;
    logic role_select;
    logic [6:0] rsvd;
    pcp_op_t op_mode;
    logic start_irq_select;
  } pcp_mode_t;

endpackage

// ---- tb/pcp_paired_channel_pwm_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcp_paired_channel_pwm_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence data_s;
    setup_s ##0 (paddr >= pcp_pkg::OFS_DATA) && (paddr < pcp_pkg::OFS_DATA + 8'h10);
  endsequence
  sequence count_s;
    setup_s ##0 (paddr >= pcp_pkg::OFS_COUNT) && (paddr < pcp_pkg::OFS_COUNT + 8'h10);
  endsequence
  a_ready_after_setup: assert property (setup_s |=> pready)
    else $error("no pready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_from_setup: assert property (pready |-> $past(psel) && !$past(penable))
    else $error("pready without setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (setup_s ##0 (paddr == 8'h80) |=> pslverr)
    else $error("no error on unmapped address");
  a_data_no_err: assert property (data_s |=> pready && !pslverr)
    else $error("error on data register");
  a_count_no_err: assert property (count_s |=> pready && !pslverr)
    else $error("error on count register");
  a_rdata_holds: assert property (!$stable(prdata) |-> pready && !pwrite)
    else $error("read data changed outside a read");
endmodule
bind pcp_paired_channel_pwm pcp_paired_channel_pwm_props u_props (
  .clk(clk),
  .resetn(resetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr)
);
`default_nettype wire

// ---- tb/pcp_paired_channel_pwm_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module pcp_paired_channel_pwm_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] event_in = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] timer_out;
  logic [3:0] chan_irq;
  logic [1:0] upper_irq;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int irq0_cnt = 0;
  always #10 clk = ~clk;
  pcp_paired_channel_pwm DUT (
    .clk(clk),
    .resetn(resetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .event_in(event_in),
    .timer_out(timer_out),
    .chan_irq(chan_irq),
    .upper_irq(upper_irq)
  );
  task test_done;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      num_errors++;
      test_done;
    end
  end
  always @(posedge clk)
    if (chan_irq[0] === 1'b1)
      irq0_cnt <= irq0_cnt + 1;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] adr(input logic [7:0] base, input int n);
    return base + 8'(4 * n);
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk(32'(e), 32'h0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask
  task per(input int ch, output int n);
    while (chan_irq[ch] !== 1'b1)
      @(posedge clk);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (chan_irq[ch] !== 1'b1);
  endtask
  task t_regs;
    logic [31:0] r;
    logic e;
    rd(pcp_pkg::OFS_PRESCALER, 32'h0);
    rd(pcp_pkg::OFS_ENABLE, 32'h0);
    for (int n = 0; n < 4; n++)
    begin
      rd(adr(pcp_pkg::OFS_DATA, n), 32'hFFFF);
      rd(adr(pcp_pkg::OFS_COUNT, n), 32'hFFFF);
      wr(adr(pcp_pkg::OFS_MODE, n), 32'hFFFFFFFF);
      rd(adr(pcp_pkg::OFS_MODE, n), 32'(n == 0 ? pcp_pkg::MODE_WMASK_PLAIN : pcp_pkg::MODE_WMASK_ROLE));
      wr(adr(pcp_pkg::OFS_MODE, n), 32'h0);
    end
    wr(pcp_pkg::OFS_COUNT, 32'h1234);
    rd(pcp_pkg::OFS_COUNT, 32'hFFFF);
    wr(pcp_pkg::OFS_DATA, 32'h1234);
    rd(pcp_pkg::OFS_DATA, 32'h1234);
    apb(1'b0, 8'h80, 32'h0, r, e);
    chk(32'(e), 32'h1);
  endtask
  task t_pwm(input int ms, input int sl, input logic [7:0] pre, input int ck, input int m, input int w);
    int dv;
    int n;
    dv = 1 << (ck != 0 ? pre[7:4] : pre[3:0]);
    wr(pcp_pkg::OFS_PRESCALER, 32'(pre));
    wr(adr(pcp_pkg::OFS_MODE, ms), 32'(ck << 14) | (ms == 2 ? 32'h800 : 32'h0));
    wr(adr(pcp_pkg::OFS_MODE, sl), 32'(ck << 14) | 32'h8);
    wr(adr(pcp_pkg::OFS_DATA, ms), 32'(m));
    wr(adr(pcp_pkg::OFS_DATA, sl), 32'(w));
    wr(pcp_pkg::OFS_OUTCTL, 32'(1 << sl));
    wr(pcp_pkg::OFS_START, 32'((1 << ms) | (1 << sl)));
    rd(pcp_pkg::OFS_ENABLE, 32'((1 << ms) | (1 << sl)));
    per(ms, n);
    chk(32'(n), 32'((m + 1) * dv));
    per(sl, n);
    chk(32'(n), 32'((m + 1) * dv));
    while (timer_out[sl] === 1'b1)
      @(posedge clk);
    while (timer_out[sl] !== 1'b1)
      @(posedge clk);
    n = 0;
    while (timer_out[sl] === 1'b1)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(n), 32'(w * dv));
    wr(pcp_pkg::OFS_STOP, 32'((1 << ms) | (1 << sl)));
    rd(pcp_pkg::OFS_ENABLE, 32'h0);
    n = 0;
    repeat (3 * (m + 1) * dv)
    begin
      @(posedge clk);
      n += int'(chan_irq[ms] === 1'b1);
    end
    chk(32'(n), 32'h0);
    wr(pcp_pkg::OFS_OUTCTL, 32'h0);
  endtask
  task t_start_irq;
    int n;
    wr(pcp_pkg::OFS_MODE, 32'h1);
    wr(pcp_pkg::OFS_DATA, 32'h64);
    for (int k = 1; k >= 0; k--)
    begin
      wr(pcp_pkg::OFS_MODE, 32'(k));
      n = irq0_cnt;
      wr(pcp_pkg::OFS_START, 32'h1);
      repeat (4)
        @(posedge clk);
      chk(32'(irq0_cnt - n), 32'(k));
      wr(pcp_pkg::OFS_STOP, 32'h1);
    end
  endtask
  task t_event;
    int n;
    wr(pcp_pkg::OFS_MODE, 32'h1000);
    wr(pcp_pkg::OFS_DATA, 32'h2);
    wr(pcp_pkg::OFS_START, 32'h1);
    n = irq0_cnt;
    repeat (6)
    begin
      event_in <= 4'h1;
      repeat (2)
        @(posedge clk);
      event_in <= 4'h0;
      repeat (2)
        @(posedge clk);
    end
    repeat (4)
      @(posedge clk);
    chk(32'(irq0_cnt - n), 32'h2);
    wr(pcp_pkg::OFS_STOP, 32'h1);
    wr(pcp_pkg::OFS_MODE, 32'h0);
  endtask
  task t_split;
    int n;
    wr(pcp_pkg::OFS_PRESCALER, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      wr(adr(pcp_pkg::OFS_MODE, 1 + 2 * i), 32'h800);
      wr(adr(pcp_pkg::OFS_DATA, 1 + 2 * i), 32'h1300);
      wr(pcp_pkg::OFS_START, 32'(1 << (9 + 2 * i)));
      rd(pcp_pkg::OFS_ENABLE, 32'(1 << (9 + 2 * i)));
      n = 0;
      repeat (600)
      begin
        @(posedge clk);
        n += int'(upper_irq[i] === 1'b1);
      end
      chk(32'(n), 32'h1E);
      wr(pcp_pkg::OFS_STOP, 32'(1 << (9 + 2 * i)));
      rd(pcp_pkg::OFS_ENABLE, 32'h0);
      wr(adr(pcp_pkg::OFS_MODE, 1 + 2 * i), 32'h0);
    end
  endtask
  task t_port;
    wr(pcp_pkg::OFS_OUTCTL, 32'hA00);
    repeat (2)
      @(posedge clk);
    chk(32'(timer_out), 32'hA);
    wr(pcp_pkg::OFS_OUTCTL, 32'h0);
  endtask
  initial
  begin
    repeat (5)
      @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_regs;
    t_pwm(0, 1, 8'h00, 0, 9, 3);
    t_pwm(0, 2, 8'h20, 1, 5, 2);
    t_pwm(2, 3, 8'h01, 0, 7, 5);
    t_start_irq;
    t_event;
    t_split;
    t_port;
    test_done;
  end
endmodule
`default_nettype wire
